// [src/duc_dac_update_control.sv]
// Register file, shadow code and trigger control of a 10-bit converter
//
// Functional notes
// - Enable bit drives coreEnable; shadow code reaches core regardless
// - Auto mode reloads only on trigger edge
// - Manual mode: data_high write reloads shadow
// - trigger_select picks one of eight events
// - Flag edge counts even if interrupt masked
// - Held high trigger level starts nothing new
// - Edges during conversion are dropped, not queued
// - left_adjust selects left or right alignment
// - Alignment change applies from next data_high write
// - output_pin_enable routes result to output pin
// - data_low write alone never changes shadow
// - Left aligned data_high write alone suffices
// - Auto mode reloads at each trigger edge not dropped as busy
`timescale 1ns/1ps
`include "duc_regs.svh"

module duc_dac_update_control #(
  parameter int CODE_W = 10,
  parameter int BUSY_CYCLES = `DUC_BUSY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone classic slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // Peripheral interrupt flags, same clock
  input wire logic [7:0] eventFlags,
  // Analog core side
  output logic [CODE_W-1:0] coreCode,
  output logic coreEnable,
  output logic pinDriveEnable,
  output logic conversionBusy
);
  import duc_pkg::*;

  logic [7:0] ctrl_reg;
  logic [7:0] high_reg;
  logic [7:0] low_reg;
  logic [CODE_W-1:0] staged_reg;
  logic [CODE_W-1:0] shadow_reg;
  logic [CODE_W-1:0] shadow_next;
  logic ack_reg;
  logic [31:0] datOut_reg;
  logic [31:0] readData;

  logic reqValid;
  logic wrTake;
  logic [7:0] wordAddr;
  logic selCtrl;
  logic selHigh;
  logic selLow;
  logic selStatus;
  logic wrCtrl;
  logic wrHigh;
  logic wrLow;
  logic autoMode;
  logic leftAdjust;
  logic manualLoad;
  logic triggerFire;
  logic busy;
  logic [CODE_W-1:0] writeCode;
  duc_trig_sel_t triggerSelect;

  // Builds the 10-bit code from the two data bytes
  function automatic logic [CODE_W-1:0] joinCode(
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic left
  );
    logic [CODE_W-1:0] code;
    if (left)
      code = {hi, lo[7:6]};
    else
      code = {hi[1:0], lo};
    return code;
  endfunction

  // Bus decode
  assign reqValid = wbCyc && wbStb;
  assign wordAddr = {wbAdr[7:2], 2'b00};
  assign selCtrl = (wordAddr == `DUC_ADDR_CTRL);
  assign selHigh = (wordAddr == `DUC_ADDR_HIGH);
  assign selLow = (wordAddr == `DUC_ADDR_LOW);
  assign selStatus = (wordAddr == `DUC_ADDR_STATUS);

  // Writes land at the edge where the master samples ack
  assign wrTake = reqValid && wbWe && ack_reg && wbSel[0];
  assign wrCtrl = wrTake && selCtrl;
  assign wrHigh = wrTake && selHigh;
  assign wrLow = wrTake && selLow;

  // Control fields
  assign autoMode = ctrl_reg[`DUC_ATE_BIT];
  assign leftAdjust = ctrl_reg[`DUC_LA_BIT];
  assign triggerSelect = duc_trig_sel_t'(ctrl_reg[`DUC_TS_MSB:`DUC_TS_LSB]);

  // Ack one cycle after the request, dropped in the next cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ack_reg <= 1'b0;
    else
      ack_reg <= reqValid && !ack_reg;
  end

  assign wbAck = ack_reg;

  // Control register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_reg <= `DUC_CTRL_RST;
    else if (wrCtrl)
      ctrl_reg <= wbDatIn[7:0];
  end

  // Data registers hold exactly what software wrote
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      high_reg <= `DUC_HIGH_RST;
      low_reg <= `DUC_LOW_RST;
    end
    else
    begin
      if (wrHigh)
        high_reg <= wbDatIn[7:0];
      if (wrLow)
        low_reg <= wbDatIn[7:0];
    end
  end

  // The alignment is frozen into the code when data_high is written,
  // so flipping left_adjust alone moves nothing
  assign writeCode = joinCode(wbDatIn[7:0], low_reg, leftAdjust);

  // Staged code: what a trigger will apply in auto mode
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      staged_reg <= `DUC_CODE_RST;
    else if (wrHigh)
      staged_reg <= writeCode;
  end

  assign manualLoad = wrHigh && !autoMode;

  // Shadow reload: manual write or trigger edge, never a data_low write
  always_comb
  begin
    shadow_next = shadow_reg;
    if (manualLoad)
      shadow_next = writeCode;
    else if (triggerFire)
      shadow_next = staged_reg;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      shadow_reg <= `DUC_CODE_RST;
    else
      shadow_reg <= shadow_next;
  end

  duc_trigger_edge #(
    .BUSY_CYCLES(BUSY_CYCLES)
  ) u_trig (
    .clk(clk),
    .nrst(nrst),
    .eventFlags(eventFlags),
    .triggerSelect(triggerSelect),
    .autoMode(autoMode),
    .loadPulse(manualLoad || triggerFire),
    .triggerFire(triggerFire),
    .busy(busy)
  );

  // Core outputs come straight from flops
  assign coreCode = shadow_reg;
  assign coreEnable = ctrl_reg[`DUC_EN_BIT];
  // The core always sees the code; only the pin driver is gated
  assign pinDriveEnable = ctrl_reg[`DUC_OE_BIT];
  assign conversionBusy = busy;

  // Read mux; unmapped addresses read zero and still get ack
  always_comb
  begin
    readData = 32'h0000_0000;
    if (selCtrl)
      readData[7:0] = ctrl_reg;
    else if (selHigh)
      readData[7:0] = high_reg;
    else if (selLow)
      readData[7:0] = leftAdjust ? (low_reg & `DUC_LEFT_LOW_MASK)
                                 : low_reg;
    else if (selStatus)
    begin
      readData[`DUC_STAT_CODE_MSB:0] = shadow_reg;
      readData[`DUC_STAT_BUSY_BIT] = busy;
    end
  end

  // Read data is captured with the ack and held while it stands
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      datOut_reg <= 32'h0000_0000;
    else if (reqValid && !ack_reg && !wbWe)
      datOut_reg <= readData;
  end

  assign wbDatOut = datOut_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Bus steps: a request is seen, the ack and read data follow it
  sequence reqSeen_s;
    reqValid && !ack_reg;
  endsequence

  sequence readSeen_s;
    reqValid && !ack_reg && !wbWe;
  endsequence

  sequence highWriteManual_s;
    wrHigh && !autoMode;
  endsequence

  sequence ctrlOnlyWrite_s;
    wrCtrl && !wrHigh;
  endsequence

  enable_follow_a: assert property (
    wrCtrl |=> coreEnable == $past(wbDatIn[`DUC_EN_BIT]))
    else $error("enable output does not follow control write");

  auto_only_edge_a: assert property (
    (autoMode && !wrHigh) ##1 (shadow_reg != $past(shadow_reg))
    |-> $past(triggerFire))
    else $error("auto mode shadow changed without a trigger edge");

  manual_load_a: assert property (
    highWriteManual_s |=> shadow_reg ==
      $past(joinCode(wbDatIn[7:0], low_reg, leftAdjust)))
    else $error("data_high write did not reload the shadow code");

  left_align_a: assert property (
    (wrHigh && !autoMode && leftAdjust)
    |=> shadow_reg[9:2] == $past(wbDatIn[7:0]))
    else $error("left alignment places wrong bits");

  align_delay_a: assert property (
    (ctrlOnlyWrite_s and !triggerFire) |=> $stable(shadow_reg))
    else $error("alignment change moved the shadow code");

  pin_route_a: assert property (
    wrCtrl |=> pinDriveEnable == $past(wbDatIn[`DUC_OE_BIT]))
    else $error("pin enable does not follow control write");

  low_no_effect_a: assert property (
    (wrLow && !triggerFire) |=> $stable(shadow_reg))
    else $error("data_low write changed the shadow code");

  trig_reload_a: assert property (
    (triggerFire && !manualLoad) |=> shadow_reg == $past(staged_reg))
    else $error("trigger did not reload the staged code");

  low_read_mask_a: assert property (
    (reqValid && !wbWe && !ack_reg && selLow && leftAdjust)
    |=> wbAck && (wbDatOut[5:0] == 6'h00))
    else $error("unused data_low bits read nonzero");

  ack_once_a: assert property (
    wbAck |=> !wbAck)
    else $error("ack held for more than one cycle");

  ack_answer_a: assert property (
    reqSeen_s |=> wbAck)
    else $error("request not acknowledged in the next cycle");

  ctrl_store_a: assert property (
    wrCtrl |=> ctrl_reg == $past(wbDatIn[7:0]))
    else $error("control write not stored");

  ctrl_hold_a: assert property (
    !wrCtrl |=> $stable(ctrl_reg))
    else $error("control register changed without a write");

  high_store_a: assert property (
    wrHigh |=> high_reg == $past(wbDatIn[7:0]))
    else $error("data_high write not stored");

  low_store_a: assert property (
    wrLow |=> low_reg == $past(wbDatIn[7:0]))
    else $error("data_low write not stored");

  // Lane 0 not selected: the write is acked but must not land
  sel_gate_a: assert property (
    (reqValid && wbWe && ack_reg && !wbSel[0])
    |=> ($stable(ctrl_reg) && $stable(high_reg) && $stable(low_reg)))
    else $error("write without lane 0 select changed a register");

  code_hold_a: assert property (
    (!manualLoad && !triggerFire) |=> $stable(shadow_reg))
    else $error("shadow code changed without a reload");

  auto_stage_a: assert property (
    (wrHigh && autoMode && !triggerFire) |=> $stable(shadow_reg))
    else $error("auto mode data_high write loaded the shadow code");

  manual_busy_a: assert property (
    manualLoad |=> conversionBusy)
    else $error("manual reload gave no busy window");

  read_high_a: assert property (
    (readSeen_s and selHigh)
    |=> wbDatOut == {24'h000000, $past(high_reg)})
    else $error("data_high read does not return the written value");

  read_low_a: assert property (
    (readSeen_s and (selLow && !leftAdjust))
    |=> wbDatOut == {24'h000000, $past(low_reg)})
    else $error("data_low read does not return the written value");

  read_status_a: assert property (
    (readSeen_s and selStatus)
    |=> wbDatOut[`DUC_STAT_CODE_MSB:0] == $past(shadow_reg))
    else $error("status read does not show the applied code");

  read_upper_a: assert property (
    wbAck |-> wbDatOut[31:17] == 15'h0000)
    else $error("unused read data bits are nonzero");

endmodule

// [src/duc_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef DUC_REGS_SVH
`define DUC_REGS_SVH

// Byte addresses on the register bus
`define DUC_ADDR_CTRL 8'h00
`define DUC_ADDR_HIGH 8'h04
`define DUC_ADDR_LOW 8'h08
`define DUC_ADDR_STATUS 8'h0c

// converter_control fields
`define DUC_EN_BIT 0
`define DUC_OE_BIT 1
`define DUC_LA_BIT 2
`define DUC_TS_LSB 4
`define DUC_TS_MSB 6
`define DUC_ATE_BIT 7

// Status register fields
`define DUC_STAT_CODE_MSB 9
`define DUC_STAT_BUSY_BIT 16

// Reset values
`define DUC_CTRL_RST 8'h00
`define DUC_HIGH_RST 8'h00
`define DUC_LOW_RST 8'h00
`define DUC_CODE_RST 10'h000

// Left-adjusted data_low uses only bits 7 and 6
`define DUC_LEFT_LOW_MASK 8'hc0

// Clock cycles a conversion counts as in progress after a reload
`define DUC_BUSY_CYCLES 1

`endif

// [src/duc_pkg.sv]
// Types shared by the converter update control block
package duc_pkg;

  // Trigger sources selectable by trigger_select
  typedef enum logic [2:0] {
    DUC_TRIG_CMP0 = 3'h0,
    DUC_TRIG_CMP1 = 3'h1,
    DUC_TRIG_EXT0 = 3'h2,
    DUC_TRIG_T0_CMP = 3'h3,
    DUC_TRIG_T0_OVF = 3'h4,
    DUC_TRIG_T1_CMPB = 3'h5,
    DUC_TRIG_T1_OVF = 3'h6,
    DUC_TRIG_T1_CAPT = 3'h7
  } duc_trig_sel_t;

endpackage

// [src/duc_trigger_edge.sv]
// Trigger source selection, rising edge detection and conversion busy window
`timescale 1ns/1ps
`include "duc_regs.svh"

module duc_trigger_edge #(
  parameter int BUSY_CYCLES = `DUC_BUSY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Event flags and selection
  input wire logic [7:0] eventFlags,
  input wire duc_pkg::duc_trig_sel_t triggerSelect,
  input wire logic autoMode,
  // Any shadow reload, manual or triggered
  input wire logic loadPulse,
  // Results
  output logic triggerFire,
  output logic busy
);
  import duc_pkg::*;

  localparam int CW = $clog2(BUSY_CYCLES + 1);
  localparam logic [CW-1:0] BUSY_LOAD = CW'(BUSY_CYCLES);

  logic selFlag_reg;
  logic selFlagPrev_reg;
  logic [CW-1:0] busyCnt_reg;

  // Flags are taken whether or not their interrupt is enabled
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      selFlag_reg <= 1'b0;
      selFlagPrev_reg <= 1'b0;
    end
    else
    begin
      selFlag_reg <= eventFlags[triggerSelect];
      selFlagPrev_reg <= selFlag_reg;
    end
  end

  // A level that stays high gives no edge; edges while busy are dropped
  assign triggerFire = autoMode && selFlag_reg && !selFlagPrev_reg
                       && !busy;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      busyCnt_reg <= '0;
    else if (loadPulse)
      busyCnt_reg <= BUSY_LOAD;
    else if (busyCnt_reg != '0)
      busyCnt_reg <= busyCnt_reg - CW'(1);
  end

  assign busy = (busyCnt_reg != '0);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence levelHeld_s;
    selFlagPrev_reg && selFlag_reg;
  endsequence

  trig_mux_a: assert property (
    ##1 selFlag_reg == $past(eventFlags[triggerSelect]))
    else $error("selected flag does not follow trigger_select");

  no_level_retrig_a: assert property (
    levelHeld_s |-> !triggerFire)
    else $error("trigger fired from a held level");

  busy_drop_a: assert property (
    busy |-> !triggerFire)
    else $error("trigger fired during a conversion");

  load_busy_a: assert property (
    loadPulse |=> busy)
    else $error("no busy window after a reload");

endmodule

// [dv/duc_core_model.sv]
// Behavioural model of the analog converter core and its output driver
`timescale 1ns/1ps

module duc_core_model (
  // Shadow code and controls from the block
  input wire logic [9:0] code,
  input wire logic enable,
  input wire logic pinEnable,
  // Levels inside the chip and on the output pin
  output logic [9:0] internalLevel,
  output logic [9:0] pinLevel
);
  // A disabled core shows zero, not the last code it held
  assign internalLevel = enable ? code : 10'h000;
  // Driver off reads as zero here; the real pin would float
  assign pinLevel = pinEnable ? internalLevel : 10'h000;
endmodule

// [dv/duc_testbench.sv]
// Self-checking bench for the converter update control block
`timescale 1ns/1ps
`include "duc_regs.svh"

module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0;
  logic [31:0] wbDatOut;
  logic wbAck;
  logic [7:0] eventFlags = 8'h00;
  logic [9:0] coreCode;
  logic coreEnable;
  logic pinDriveEnable;
  logic conversionBusy;
  logic [9:0] pinLevel;
  logic [31:0] rd;
  logic [9:0] staged;
  int n_errors = 0;
  int checked = 0;

  always #5 clk = ~clk;

  duc_dac_update_control dut (.clk(clk), .nrst(nrst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .eventFlags(eventFlags), .coreCode(coreCode),
    .coreEnable(coreEnable), .pinDriveEnable(pinDriveEnable),
    .conversionBusy(conversionBusy));

  duc_core_model core (.code(coreCode), .enable(coreEnable),
    .pinEnable(pinDriveEnable), .internalLevel(), .pinLevel(pinLevel));

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr,
    input logic [7:0] dat);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'h1;
    wbDatIn <= {24'h0, dat};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      $display("wrong value at %0t: no acknowledge", $time);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 8'h00);
    check(rd, exp);
  endtask

  // Settle, then compare the applied code after the edges land
  task automatic code_is(input int k, input logic [9:0] exp);
    repeat (k) @(posedge clk);
    #1;
    check({22'h0, coreCode}, {22'h0, exp});
  endtask

  task automatic flag(input logic [7:0] f);
    @(posedge clk);
    eventFlags <= f;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rdc(`DUC_ADDR_CTRL, 32'h0);
    rdc(`DUC_ADDR_HIGH, 32'h0);
    rdc(`DUC_ADDR_LOW, 32'h0);
    code_is(1, 10'h000);
    $display("test reset done");
    wr(`DUC_ADDR_CTRL, 8'h03);
    wr(`DUC_ADDR_LOW, 8'h5a);
    code_is(3, 10'h000);
    wr(`DUC_ADDR_HIGH, 8'hfe);
    code_is(3, 10'h25a);
    check({22'h0, pinLevel}, 32'h25a);
    rdc(`DUC_ADDR_HIGH, 32'hfe);
    rdc(`DUC_ADDR_LOW, 32'h5a);
    wr(`DUC_ADDR_CTRL, 8'h02);
    code_is(2, 10'h25a);
    check({22'h0, pinLevel}, 32'h0);
    wr(`DUC_ADDR_CTRL, 8'h01);
    code_is(2, 10'h25a);
    check({22'h0, pinLevel}, 32'h0);
    $display("test right alignment done");
    wr(`DUC_ADDR_CTRL, 8'h07);
    code_is(3, 10'h25a);
    wr(`DUC_ADDR_HIGH, 8'hab);
    code_is(3, 10'h2ad);
    rdc(`DUC_ADDR_LOW, 32'h40);
    wr(`DUC_ADDR_LOW, 8'h80);
    code_is(3, 10'h2ad);
    wr(`DUC_ADDR_HIGH, 8'h12);
    code_is(3, 10'h04a);
    wr(`DUC_ADDR_CTRL, 8'h03);
    code_is(3, 10'h04a);
    wr(`DUC_ADDR_HIGH, 8'h01);
    code_is(3, 10'h180);
    rdc(`DUC_ADDR_STATUS, 32'h180);
    $display("test left alignment done");
    staged = 10'h180;
    for (int s = 0; s < 8; s++)
    begin
      wr(`DUC_ADDR_CTRL, {1'b1, s[2:0], 4'h1});
      wr(`DUC_ADDR_LOW, {s[3:0], 4'h0});
      wr(`DUC_ADDR_HIGH, 8'h02);
      code_is(3, staged);
      flag(~(8'h01 << s));
      code_is(4, staged);
      flag(8'h01 << s);
      staged = {2'b10, s[3:0], 4'h0};
      code_is(2, staged);
      check({31'h0, conversionBusy}, 32'h1);
      code_is(1, staged);
      check({31'h0, conversionBusy}, 32'h0);
      // Flag still high: new data stages but must not load
      wr(`DUC_ADDR_LOW, 8'hff);
      wr(`DUC_ADDR_HIGH, 8'h01);
      code_is(4, staged);
      flag(8'h00);
      flag(8'h01 << s);
      staged = 10'h1ff;
      code_is(3, staged);
      flag(8'h00);
    end
    $display("test auto trigger done");
    wr(8'h10, 8'hff);
    rdc(8'h10, 32'h0);
    rdc(`DUC_ADDR_CTRL, 32'hf1);
    $display("test unmapped access done");
    results();
  end
endmodule
